/* rtl/adft_cfg.svh */
// task-file map, opcodes, codes, register offsets and timing counts
`ifndef ADFT_CFG_SVH
`define ADFT_CFG_SVH
// ----------------------------------------------------------------------
// task-file register addresses
// ----------------------------------------------------------------------
`define ADFT_TF_DATA 3'h0
`define ADFT_TF_FEAT 3'h1
`define ADFT_TF_SCNT 3'h2
`define ADFT_TF_SNUM 3'h3
`define ADFT_TF_CYLL 3'h4
`define ADFT_TF_CYLH 3'h5
`define ADFT_TF_DRVH 3'h6
`define ADFT_TF_CMD 3'h7
// ----------------------------------------------------------------------
// status and error bit positions, drive/head fields
// ----------------------------------------------------------------------
`define ADFT_ST_BSY 7
`define ADFT_ST_DRDY 6
`define ADFT_ST_DSC 4
`define ADFT_ST_DRQ 3
`define ADFT_ST_ERR 0
`define ADFT_ER_IDNF 4
`define ADFT_ER_ABRT 2
`define ADFT_DH_LBA 6
`define ADFT_DH_DRV 4
// ----------------------------------------------------------------------
// opcodes, diagnostic codes, defaults
// ----------------------------------------------------------------------
`define ADFT_OP_DIAG 8'h90
`define ADFT_OP_FMT 8'h50
`define ADFT_DG_OK 8'h01
`define ADFT_DG_FMTR 8'h02
`define ADFT_DG_BUF 8'h03
`define ADFT_DG_ECC 8'h04
`define ADFT_DG_CPU 8'h05
`define ADFT_DG_SLAVE 8'h80
`define ADFT_SPT_DEF 8'h20
`define ADFT_FMT_SECTORS 32
`define ADFT_SECT_WORDS 256
`define ADFT_DIAG_CYCLES 16
`define ADFT_STATUS_RST 8'h50
// ----------------------------------------------------------------------
// controller registers on apb (byte addresses)
// ----------------------------------------------------------------------
`define ADFT_A_CTRL 12'h000
`define ADFT_A_ADDR 12'h004
`define ADFT_A_RESULT 12'h008
`define ADFT_A_ISTAT 12'h00c
`define ADFT_A_IMASK 12'h010
`define ADFT_IRQ_DONE 0
`define ADFT_IRQ_ERR 1
`define ADFT_IMASK_RST 2'h0
`endif

/* rtl/adft_pkg.sv */
// types shared by both ends of the task-file link
package adft_pkg;
  typedef enum logic [2:0] {
    D_IDLE, D_DIAG, D_DATA, D_CHECK, D_ERASE, D_ERWAIT
  } adft_dstate_e;
  typedef enum logic [2:0] {
    H_IDLE, H_SEND, H_WAIT, H_DATA, H_DONE
  } adft_hstate_e;
  typedef logic [7:0] adft_byte_t;
endpackage

/* rtl/adft_tf_if.sv */
// task-file link between the ata host controller and the card
`timescale 1ns/10ps
`default_nettype none
interface adft_tf_if;
  logic wr;
  logic [2:0] addr;
  logic [15:0] wdata;
  logic [7:0] status;
  logic [7:0] error;
  modport dev_mp (input wr, addr, wdata, output status, error);
  modport host_mp (output wr, addr, wdata, input status, error);
endinterface
`default_nettype wire

/* rtl/adft_addr.sv */
// start-address decode and validity check for format track
`timescale 1ns/10ps
`default_nettype none
module adft_addr
  import adft_pkg::*;
(
  // task-file address fields
  input wire logic lba_mode,
  input wire logic [3:0] head,
  input wire logic [7:0] cylh,
  input wire logic [7:0] cyll,
  input wire logic [7:0] snum,
  // geometry
  input wire logic [7:0] spt,
  input wire logic [4:0] heads,
  input wire logic [15:0] cyls,
  input wire logic [27:0] capacity,
  // result
  output logic [27:0] lba,
  output logic valid
);
  logic [15:0] cyl;
  logic [20:0] trk;
  logic [28:0] chs_lba;
  assign cyl = {cylh, cyll};
  // widen before multiplying so the product keeps its top bits
  assign trk = 21'(cyl) * 21'(heads) + 21'(head);
  assign chs_lba = 29'(trk) * 29'(spt) + 29'(snum) - 29'h1;
  always_comb begin
    if (lba_mode) begin
      lba = {head, cylh, cyll, snum};
      valid = lba < capacity;
    end else begin
      lba = chs_lba[27:0];
      // sectors count from one in chs
      valid = (snum != 8'h00) && (snum <= spt) && ({1'b0, head} < heads) &&
              (cyl < cyls) && (chs_lba < {1'b0, capacity});
    end
  end
endmodule
`default_nettype wire

/* rtl/adft_dev.sv */
// card end: task file, drive diagnostic and format track
//
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "adft_cfg.svh"
// Operation
// (R1) opcode 90h starts self-diagnostic
// (R2) diagnostic result code goes in error
// (R3) codes 01h ok, 02h-05h component faults
// (R4) code 8xh: secondary drive failed, ide
// (R5) diagnostic end status: ready, seek complete
// (R6) opcode 50h starts format track
// (R7) format erases sectors from start, count per R9-R11
// (R8) invalid start: set idnf, no erase
// (R9) chs count is current sectors per track
// (R10) initialised geometry overrides sectors per track
// (R11) lba count comes from sector count
// (R12) one host sector accepted, then dropped
// (R13) host drive/head: lba, drive, head bits
// (R14) host cylinder registers carry address bytes
// (R15) lba mode: sector number holds lba low
// (R16) format end status; only abort error
// (R17) host waits for busy clear
module adft_dev
  import adft_pkg::*;
#(
  parameter int DIAG_CYCLES = `ADFT_DIAG_CYCLES,
  parameter int SECT_WORDS = `ADFT_SECT_WORDS
)(
  // clock, reset, enable
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  // task-file link
  adft_tf_if.dev_mp tf,
  // self-test results
  input wire logic [3:0] selftest_fail,
  input wire logic slave_fail,
  input wire logic true_ide,
  // geometry
  input wire logic spt_init_valid,
  input wire logic [7:0] spt_init,
  input wire logic [4:0] num_heads,
  input wire logic [15:0] num_cyls,
  input wire logic [27:0] capacity,
  // media erase
  output logic erase_req,
  output logic [27:0] erase_lba,
  input wire logic erase_done,
  input wire logic erase_fail
);
  initial begin
    if (DIAG_CYCLES < 1 || DIAG_CYCLES > 65535 ||
        SECT_WORDS < 1 || SECT_WORDS > 65536) begin
      $error("adft_dev: bad parameter");
    end
  end

  typedef struct packed {
    adft_dstate_e state;
    logic [15:0] cnt;
    logic [8:0] left;
    adft_byte_t scnt;
    adft_byte_t snum;
    adft_byte_t cyll;
    adft_byte_t cylh;
    adft_byte_t drvh;
    adft_byte_t status;
    adft_byte_t error;
    logic erase_req;
    logic [27:0] erase_lba;
  } adft_dev_s;

  adft_dev_s s, next_s;
  logic [7:0] spt_eff;
  logic [27:0] start_lba;
  logic start_ok;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic adft_byte_t mk_status(input logic bsy, input logic drq,
                                           input logic err);
    adft_byte_t v;
    v = 8'h00;
    v[`ADFT_ST_BSY] = bsy;
    v[`ADFT_ST_DRDY] = 1'b1;
    v[`ADFT_ST_DSC] = 1'b1;
    v[`ADFT_ST_DRQ] = drq;
    v[`ADFT_ST_ERR] = err;
    return v;
  endfunction

  function automatic adft_byte_t diag_code(input logic [3:0] fail);
    adft_byte_t v;
    v = `ADFT_DG_OK; // see R3
    if (fail[3]) v = `ADFT_DG_CPU;
    if (fail[2]) v = `ADFT_DG_ECC;
    if (fail[1]) v = `ADFT_DG_BUF;
    if (fail[0]) v = `ADFT_DG_FMTR;
    return v;
  endfunction

  // geometry may be changed by the initialise-parameters command
  assign spt_eff = spt_init_valid ? spt_init : `ADFT_SPT_DEF; // see R9 R10

  adft_addr u_addr (
    .lba_mode(s.drvh[`ADFT_DH_LBA]),
    .head(s.drvh[3:0]),
    .cylh(s.cylh),
    .cyll(s.cyll),
    .snum(s.snum),
    .spt(spt_eff),
    .heads(num_heads),
    .cyls(num_cyls),
    .capacity(capacity),
    .lba(start_lba),
    .valid(start_ok)
  );

  // ----------------------------------------------------------------------
  // command engine
  // ----------------------------------------------------------------------
  always_comb begin
    adft_byte_t code;
    code = diag_code(selftest_fail);
    next_s = s;
    unique case (s.state)
      D_IDLE: begin
        // register writes are ignored while busy, as on any ata drive
        if (tf.wr) begin
          unique case (tf.addr)
            `ADFT_TF_SCNT: next_s.scnt = tf.wdata[7:0];
            `ADFT_TF_SNUM: next_s.snum = tf.wdata[7:0];
            `ADFT_TF_CYLL: next_s.cyll = tf.wdata[7:0];
            `ADFT_TF_CYLH: next_s.cylh = tf.wdata[7:0];
            `ADFT_TF_DRVH: next_s.drvh = tf.wdata[7:0]; // see R13
            `ADFT_TF_CMD: begin
              next_s.error = 8'h00;
              if (tf.wdata[7:0] == `ADFT_OP_DIAG) begin // see R1
                next_s.state = D_DIAG;
                next_s.cnt = 16'(DIAG_CYCLES);
                next_s.status = mk_status(1'b1, 1'b0, 1'b0);
              end else if (tf.wdata[7:0] == `ADFT_OP_FMT) begin // see R6
                // features and data port are not parameters here
                next_s.state = D_DATA;
                next_s.cnt = 16'(SECT_WORDS - 1);
                next_s.status = mk_status(1'b0, 1'b1, 1'b0);
              end else begin
                next_s.error[`ADFT_ER_ABRT] = 1'b1;
                next_s.status = mk_status(1'b0, 1'b0, 1'b1);
              end
            end
            default: ;
          endcase
        end
      end
      D_DIAG: begin
        if (s.cnt > 16'h0001) begin
          next_s.cnt = s.cnt - 16'h0001;
        end else begin
          next_s.state = D_IDLE;
          if (true_ide && slave_fail) begin
            next_s.error = `ADFT_DG_SLAVE | {4'h0, code[3:0]}; // see R4
          end else begin
            next_s.error = code; // see R2 R3
          end
          next_s.status = mk_status(1'b0, 1'b0,
                                    next_s.error != `ADFT_DG_OK); // see R5
        end
      end
      D_DATA: begin
        // the legacy sector is counted in and thrown away
        if (tf.wr && tf.addr == `ADFT_TF_DATA) begin // see R12
          if (s.cnt == 16'h0000) begin
            next_s.state = D_CHECK;
            next_s.status = mk_status(1'b1, 1'b0, 1'b0);
          end else begin
            next_s.cnt = s.cnt - 16'h0001;
          end
        end
      end
      D_CHECK: begin
        if (!start_ok) begin
          next_s.state = D_IDLE;
          next_s.error[`ADFT_ER_IDNF] = 1'b1; // see R8
          next_s.status = mk_status(1'b0, 1'b0, 1'b1);
        end else begin
          next_s.state = D_ERASE;
          next_s.erase_lba = start_lba; // see R7
          if (s.drvh[`ADFT_DH_LBA]) begin
            next_s.left = (s.scnt == 8'h00) ? 9'h100 : {1'b0, s.scnt}; // see R11
          end else begin
            next_s.left = {1'b0, spt_eff}; // see R9 R10
          end
        end
      end
      D_ERASE: begin
        next_s.erase_req = 1'b1;
        next_s.state = D_ERWAIT;
      end
      D_ERWAIT: begin
        if (erase_done || erase_fail) begin
          next_s.erase_req = 1'b0;
          next_s.left = s.left - 9'h001;
          next_s.erase_lba = s.erase_lba + 28'h1;
          if (erase_fail) begin
            next_s.state = D_IDLE;
            next_s.error[`ADFT_ER_ABRT] = 1'b1; // see R16
            next_s.status = mk_status(1'b0, 1'b0, 1'b1);
          end else if (s.left == 9'h001) begin
            next_s.state = D_IDLE;
            next_s.status = mk_status(1'b0, 1'b0, 1'b0); // see R16
          end else begin
            next_s.state = D_ERASE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.state <= D_IDLE;
      s.status <= `ADFT_STATUS_RST;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign tf.status = s.status;
  assign tf.error = s.error;
  assign erase_req = s.erase_req;
  assign erase_lba = s.erase_lba;
endmodule
`default_nettype wire

/* rtl/adft_host.sv */
// host end: apb-driven controller that issues the two commands
`timescale 1ns/10ps
`default_nettype none
`include "adft_cfg.svh"
module adft_host
  import adft_pkg::*;
#(
  parameter int SECT_WORDS = `ADFT_SECT_WORDS
)(
  // clock, reset, enable
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq,
  // task-file link
  adft_tf_if.host_mp tf
);
  initial begin
    if (SECT_WORDS < 1 || SECT_WORDS > 65536) begin
      $error("adft_host: bad parameter");
    end
  end

  typedef struct packed {
    adft_hstate_e state;
    logic [2:0] step;
    logic [15:0] cnt;
    logic sent;
    logic [23:0] ctrl;
    logic [27:0] addr;
    logic [15:0] result;
    logic [1:0] istat;
    logic [1:0] imask;
    logic [31:0] prdata;
    logic pready;
    logic irq;
    logic wr;
    logic [2:0] tfa;
    logic [15:0] tfd;
  } adft_host_s;

  adft_host_s s, next_s;
  logic acc;
  logic wacc;

  // order of task-file writes; the command byte goes last
  function automatic logic [2:0] step_addr(input logic [2:0] i);
    logic [2:0] a;
    unique case (i)
      3'h0: a = `ADFT_TF_DRVH;
      3'h1: a = `ADFT_TF_CYLH;
      3'h2: a = `ADFT_TF_CYLL;
      3'h3: a = `ADFT_TF_SNUM;
      3'h4: a = `ADFT_TF_SCNT;
      default: a = `ADFT_TF_CMD;
    endcase
    return a;
  endfunction

  assign acc = psel && penable && !s.pready;
  // writes land at the edge where the master sees pready, not before
  assign wacc = psel && penable && s.pready;

  always_comb begin
    logic [1:0] ev;
    logic [2:0] a;
    ev = 2'h0;
    a = step_addr(s.step);
    next_s = s;
    next_s.wr = 1'b0;
    next_s.pready = acc;
    // ----------------------------------------------------------------------
    // command sequencer
    // ----------------------------------------------------------------------
    unique case (s.state)
      H_IDLE: ;
      H_SEND: begin
        next_s.wr = 1'b1;
        next_s.tfa = a;
        unique case (a)
          `ADFT_TF_DRVH: next_s.tfd = {8'h00, 1'b1, s.ctrl[8], 1'b1,
                                       s.ctrl[9], s.addr[27:24]}; // see R13
          `ADFT_TF_CYLH: next_s.tfd = {8'h00, s.addr[23:16]}; // see R14
          `ADFT_TF_CYLL: next_s.tfd = {8'h00, s.addr[15:8]}; // see R14
          `ADFT_TF_SNUM: next_s.tfd = {8'h00, s.addr[7:0]}; // see R15
          `ADFT_TF_SCNT: next_s.tfd = {8'h00, s.ctrl[23:16]}; // see R11
          default: next_s.tfd = {8'h00, s.ctrl[7:0]}; // see R1 R6
        endcase
        if (a == `ADFT_TF_CMD) begin
          next_s.state = H_WAIT;
        end else begin
          next_s.step = s.step + 3'h1;
        end
      end
      H_WAIT: begin
        // while our last write is still on the link the status predates it
        if (!s.wr && !tf.status[`ADFT_ST_BSY]) begin // see R17
          if (tf.status[`ADFT_ST_DRQ] && !s.sent) begin
            next_s.state = H_DATA;
            next_s.cnt = 16'(SECT_WORDS - 1);
          end else begin
            next_s.state = H_DONE;
          end
        end
      end
      H_DATA: begin
        // filler sector; its content is of no use to the card
        next_s.wr = 1'b1;
        next_s.tfa = `ADFT_TF_DATA;
        next_s.tfd = 16'h0000; // see R12
        if (s.cnt == 16'h0000) begin
          next_s.sent = 1'b1;
          next_s.state = H_WAIT;
        end else begin
          next_s.cnt = s.cnt - 16'h0001;
        end
      end
      H_DONE: begin
        next_s.result = {tf.error, tf.status};
        ev[`ADFT_IRQ_DONE] = 1'b1;
        ev[`ADFT_IRQ_ERR] = tf.status[`ADFT_ST_ERR];
        next_s.state = H_IDLE;
      end
    endcase
    // ----------------------------------------------------------------------
    // apb registers
    // ----------------------------------------------------------------------
    if (wacc && pwrite) begin
      unique case (paddr)
        `ADFT_A_CTRL: begin
          // a new order while one is running is dropped
          if (s.state == H_IDLE) begin
            next_s.ctrl = pwdata[23:0];
            next_s.state = H_SEND;
            next_s.step = 3'h0;
            next_s.sent = 1'b0;
          end
        end
        `ADFT_A_ADDR: next_s.addr = pwdata[27:0];
        `ADFT_A_ISTAT: next_s.istat = s.istat & ~pwdata[1:0];
        `ADFT_A_IMASK: next_s.imask = pwdata[1:0];
        default: ;
      endcase
    end
    // a new event wins over a clear in the same cycle
    next_s.istat = next_s.istat | ev;
    if (acc && !pwrite) begin
      unique case (paddr)
        `ADFT_A_CTRL: next_s.prdata = {8'h00, s.ctrl};
        `ADFT_A_ADDR: next_s.prdata = {4'h0, s.addr};
        `ADFT_A_RESULT: next_s.prdata = {15'h0000, s.state != H_IDLE,
                                         s.result};
        `ADFT_A_ISTAT: next_s.prdata = {30'h0, s.istat};
        `ADFT_A_IMASK: next_s.prdata = {30'h0, s.imask};
        default: next_s.prdata = 32'h0000_0000;
      endcase
    end
    next_s.irq = |(next_s.istat & next_s.imask);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
      s.state <= H_IDLE;
      s.imask <= `ADFT_IMASK_RST;
    end else if (ce) begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = 1'b0;
  assign irq = s.irq;
  assign tf.wr = s.wr;
  assign tf.addr = s.tfa;
  assign tf.wdata = s.tfd;
endmodule
`default_nettype wire

/* tb/adft_tf_assertions.sv */
// concurrent checks on the task-file link between host and card
`timescale 1ns/10ps
`default_nettype none
module adft_tf_assertions (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // task-file link
  input wire logic wr,
  input wire logic [2:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [7:0] status,
  input wire logic [7:0] error
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  logic diag_run;
  logic fmt_run;
  logic bsy_q;
  wire logic idle = !status[7] && !status[3];
  wire logic fin = bsy_q && !status[7];
  // ----------------------------------------------------------------
  // command tracking
  // ----------------------------------------------------------------
  sequence s_diag_cmd;
    wr && addr == 3'h7 && wdata[7:0] == 8'h90 && idle;
  endsequence
  sequence s_fmt_cmd;
    wr && addr == 3'h7 && wdata[7:0] == 8'h50 && idle;
  endsequence
  // remembers which command owns the next fall of busy
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      diag_run <= 1'b0;
      fmt_run <= 1'b0;
      bsy_q <= 1'b0;
    end else begin
      bsy_q <= status[7];
      if (wr && addr == 3'h7 && idle) begin
        diag_run <= wdata[7:0] == 8'h90;
        fmt_run <= wdata[7:0] == 8'h50;
      end else if (fin) begin
        diag_run <= 1'b0;
        fmt_run <= 1'b0;
      end
    end
  end
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_reset_status: assert property ($rose(nrst) |-> status == 8'h50)
    else $error("status after reset is wrong");
  a_diag_busy: assert property (s_diag_cmd |=> status[7])
    else $error("diagnostic did not raise busy");
  a_diag_len: assert property (
    s_diag_cmd |=> status[7] [*8] ##[1:40] !status[7])
    else $error("diagnostic busy time out of range");
  a_diag_end: assert property (diag_run && fin |->
    status[6] && status[4] && !status[5] && !status[1])
    else $error("diagnostic end status is wrong");
  a_diag_code: assert property (diag_run && fin |->
    (error inside {[8'h01:8'h05]} || error[7:4] == 4'h8) &&
    status[0] == (error != 8'h01))
    else $error("diagnostic code or error flag is wrong");
  a_fmt_drq: assert property (s_fmt_cmd |=> status[3] && !status[7])
    else $error("format did not request its data sector");
  a_fmt_end: assert property (fmt_run && fin |->
    status[6] && status[4] && !status[5] && !status[1])
    else $error("format end status is wrong");
  a_fmt_err: assert property (fmt_run && fin |->
    (error & 8'heb) == 8'h00 && status[0] == (error != 8'h00))
    else $error("format error flags are wrong");
  a_idle_ready: assert property (!status[7] |->
    status[6] && status[4] && !status[5] && !status[1])
    else $error("ready bits wrong while not busy");
endmodule
`default_nettype wire

/* tb/ata_diag_format_track_cmds_tb_top.sv */
// self-checking bench: host and card joined, driven over apb
`timescale 1ns/10ps
`default_nettype none
module ata_diag_format_track_cmds_tb_top import adft_pkg::*;;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, irq, erase_req;
  logic erase_done = 1'b0;
  logic erase_fail = 1'b0;
  logic fail_mode = 1'b0;
  logic ce = 1'b1;
  logic [4:0] num_heads = 5'h04;
  logic [15:0] num_cyls = 16'h0064;
  logic [27:0] capacity = 28'h0010000;
  logic [3:0] selftest_fail = 4'h0;
  logic slave_fail = 1'b0;
  logic true_ide = 1'b0;
  logic spt_init_valid = 1'b0;
  logic [7:0] spt_init = 8'h10;
  logic [1:0] imask = 2'h0;
  logic [27:0] erase_lba;
  logic [27:0] first_lba = 28'h0;
  logic [3:0] fails [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h0};
  logic [7:0] codes [6] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h81};
  int n_erase = 0;
  int ecnt = 0;
  int n_mismatch = 0;
  int check_count = 0;
  adft_tf_if tf ();
  always #20 clock = ~clock;
  // ----------------------------------------------------------------
  // the two ends and the checker
  // ----------------------------------------------------------------
  adft_host #(.SECT_WORDS(4)) u_adft_host (.clock(clock), .nrst(nrst),
    .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .tf(tf.host_mp));
  adft_dev #(.DIAG_CYCLES(16), .SECT_WORDS(4)) u_adft_dev (.clock(clock),
    .nrst(nrst), .ce(ce), .tf(tf.dev_mp), .selftest_fail(selftest_fail),
    .slave_fail(slave_fail), .true_ide(true_ide),
    .spt_init_valid(spt_init_valid), .spt_init(spt_init),
    .num_heads(num_heads), .num_cyls(num_cyls), .capacity(capacity),
    .erase_req(erase_req), .erase_lba(erase_lba),
    .erase_done(erase_done), .erase_fail(erase_fail));
  adft_tf_assertions u_adft_tf_assertions (.clock(clock), .nrst(nrst),
    .wr(tf.wr), .addr(tf.addr), .wdata(tf.wdata), .status(tf.status),
    .error(tf.error));
  // media stand-in: a slow erase shows the card really waits for it
  always @(posedge clock) begin
    if (erase_req && ecnt == 3) begin
      erase_done <= !fail_mode;
      erase_fail <= fail_mode;
      ecnt <= 0;
      if (n_erase == 0) first_lba <= erase_lba;
      n_erase <= n_erase + 1;
    end else begin
      erase_done <= 1'b0;
      erase_fail <= 1'b0;
      ecnt <= erase_req ? ecnt + 1 : 0;
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask
  task automatic run_cmd(input logic [27:0] av, input logic [31:0] cv,
      input logic [15:0] res, input logic [1:0] ist);
    n_erase = 0;
    apb(1'b1, 12'h004, {4'h0, av});
    apb(1'b1, 12'h000, cv);
    do apb(1'b0, 12'h008, 32'h0); while (q[16] !== 1'b0);
    apb(1'b0, 12'h008, 32'h0);
    chk(q, {16'h0, res});
    apb(1'b0, 12'h00c, 32'h0);
    chk(q, {30'h0, ist});
    chk({31'h0, irq}, {31'h0, |(ist & imask)});
    apb(1'b1, 12'h00c, 32'h3);
    @(posedge clock);
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic end_of_test;
    $display("mismatches %0d, checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    #(40 * 30000);
    n_mismatch++;
    end_of_test;
  end
  initial begin
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    apb(1'b0, 12'h008, 32'h0);
    // no command has run yet, so no result has been captured
    chk(q, 32'h0000_0000);
    apb(1'b1, 12'h020, 32'hffff_ffff);
    apb(1'b0, 12'h020, 32'h0);
    chk(q, 32'h0);
    chk({31'h0, pslverr}, 32'h0);
    // mask opens after two runs, so both irq states are seen
    for (int i = 0; i < 6; i++) begin
      selftest_fail <= fails[i];
      // a slave failure outside true ide mode must not show
      slave_fail <= i >= 4;
      true_ide <= i == 5;
      if (i == 2) begin
        imask = 2'h3;
        apb(1'b1, 12'h010, 32'h3);
      end
      run_cmd(28'h0, 32'h90, {codes[i], i == 0 ? 8'h50 : 8'h51},
        i == 0 ? 2'h1 : 2'h3);
    end
    // with ce low both ends freeze, so busy outlasts the diagnostic time
    apb(1'b1, 12'h000, 32'h90);
    ce <= 1'b0;
    repeat (40) @(posedge clock);
    ce <= 1'b1;
    apb(1'b0, 12'h008, 32'h0);
    chk({31'h0, q[16]}, 32'h1);
    do apb(1'b0, 12'h008, 32'h0); while (q[16] !== 1'b0);
    chk(q, 32'h0000_8151);
    apb(1'b1, 12'h00c, 32'h3);
    run_cmd(28'h1000201, 32'h50, 16'h0050, 2'h1);
    chk(n_erase, 32);
    chk({4'h0, first_lba}, 32'h120);
    spt_init_valid <= 1'b1;
    run_cmd(28'h1000201, 32'h50, 16'h0050, 2'h1);
    chk(n_erase, 16);
    chk({4'h0, first_lba}, 32'h90);
    spt_init_valid <= 1'b0;
    run_cmd(28'h0000100, 32'h0005_0150, 16'h0050, 2'h1);
    chk(n_erase, 5);
    chk({4'h0, first_lba}, 32'h100);
    run_cmd(28'h1000200, 32'h50, 16'h1051, 2'h3);
    chk(n_erase, 0);
    num_heads <= 5'h01;
    run_cmd(28'h1000201, 32'h50, 16'h1051, 2'h3);
    chk(n_erase, 0);
    num_heads <= 5'h04;
    run_cmd(28'h0010000, 32'h0001_0150, 16'h1051, 2'h3);
    chk(n_erase, 0);
    fail_mode <= 1'b1;
    run_cmd(28'h1000201, 32'h50, 16'h0451, 2'h3);
    chk(n_erase, 1);
    fail_mode <= 1'b0;
    end_of_test;
  end
endmodule
`default_nettype wire
